/* core/tmi_top.sv */
`timescale 1ns/1ps
`include "tmi_consts.svh"
module tmi_top
  import tmi_pkg::*;
#(
  parameter bit HAS_CT1 = 1'b1,       // Second compact timer present
  parameter bit HAS_ST0 = 1'b1,       // Standard timer present
  parameter bit HAS_PT1 = 1'b1        // Second periodic timer present
) (
  input  wire logic        aclk,      // Clock
  input  wire logic        aresetn,   // Sync reset, low
  input  wire logic        ce,        // Clock enable
  input  tmi_src_s         match_evt, // Timer match pulses
  output tmi_src_s         irq_req,   // Enabled pending sources
  output logic             irq,       // Interrupt level
  input  wire logic [7:0]  awaddr,    // Write address
  input  wire logic [2:0]  awprot,    // Unused
  input  wire logic        awvalid,   // Write address valid
  output logic             awready,   // Write address ready
  input  wire logic [31:0] wdata,     // Write data
  input  wire logic [3:0]  wstrb,     // Byte enables
  input  wire logic        wvalid,    // Write data valid
  output logic             wready,    // Write data ready
  output logic [1:0]       bresp,     // Write response
  output logic             bvalid,    // Write response valid
  input  wire logic        bready,    // Write response ready
  input  wire logic [7:0]  araddr,    // Read address
  input  wire logic [2:0]  arprot,    // Unused
  input  wire logic        arvalid,   // Read address valid
  output logic             arready,   // Read address ready
  output logic [31:0]      rdata,     // Read data
  output logic [1:0]       rresp,     // Read response
  output logic             rvalid,    // Read data valid
  input  wire logic        rready     // Read data ready
);

  localparam logic [9:0] IMPL = {{2{HAS_PT1}}, {2{HAS_ST0}}, 2'h3,
                                 {2{HAS_CT1}}, 2'h3};

  tmi_state_s s;
  tmi_state_s next_s;
  logic [9:0] next_flag;
  logic [9:0] wr_fmask;
  logic [9:0] wr_fval;
  logic [9:0] wr_clr;
  logic       do_write;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  tmi_sel_e   wsel;
  tmi_sel_e   rsel;
  logic [11:0] nib_sel;
  logic [11:0] flag_rep;
  logic [11:0] en_rep;

  function automatic tmi_sel_e tmi_decode(input logic [7:0] a);
    case (a)
      `TMI_OFS_COMPACT:   return TMI_SEL_COMPACT;
      `TMI_OFS_PERIODIC0: return TMI_SEL_PERIODIC0;
      `TMI_OFS_PERIODIC1: return TMI_SEL_PERIODIC1;
      `TMI_OFS_CONTROL:   return TMI_SEL_CONTROL;
      `TMI_OFS_STATUS:    return TMI_SEL_STATUS;
      `TMI_OFS_MASK:      return TMI_SEL_MASK;
      default:            return TMI_SEL_NONE;
    endcase
  endfunction : tmi_decode

  // Source pairs that an 8-bit register write lands on
  function automatic logic [11:0] tmi_nibble(input tmi_sel_e sel);
    case (sel)
      TMI_SEL_COMPACT:   return 12'h00F;
      TMI_SEL_PERIODIC0: return 12'h0F0;
      TMI_SEL_PERIODIC1: return 12'hF00;
      default:           return 12'h000;
    endcase
  endfunction : tmi_nibble

  // Register r shows pair 2r in the low nibble pair, pair 2r+1 in the high
  function automatic logic [7:0] tmi_view(input int r, input logic [9:0] f,
                                          input logic [9:0] e);
    logic [11:0] fx;
    logic [11:0] ex;
    logic [7:0]  v;
    fx = {2'h0, f & IMPL};
    ex = {2'h0, e & IMPL};
    v  = 8'h00;
    v[`TMI_BIT_LO_P_FLAG] = fx[4*r];
    v[`TMI_BIT_LO_A_FLAG] = fx[4*r+1];
    v[`TMI_BIT_HI_P_FLAG] = fx[4*r+2];
    v[`TMI_BIT_HI_A_FLAG] = fx[4*r+3];
    v[`TMI_BIT_LO_P_EN]   = ex[4*r];
    v[`TMI_BIT_LO_A_EN]   = ex[4*r+1];
    v[`TMI_BIT_HI_P_EN]   = ex[4*r+2];
    v[`TMI_BIT_HI_A_EN]   = ex[4*r+3];
    return v;
  endfunction : tmi_view

  function automatic logic [31:0] tmi_read(input tmi_sel_e sel, input tmi_state_s st);
    unique case (sel)
      TMI_SEL_COMPACT:   return {24'h000000, tmi_view(0, st.flag, st.en)};
      TMI_SEL_PERIODIC0: return {24'h000000, tmi_view(1, st.flag, st.en)};
      TMI_SEL_PERIODIC1: return {24'h000000, tmi_view(2, st.flag, st.en)};
      TMI_SEL_CONTROL:   return {31'h00000000, st.gie};
      TMI_SEL_STATUS:    return {22'h000000, st.flag & IMPL};
      TMI_SEL_MASK:      return {22'h000000, st.en & IMPL};
      TMI_SEL_NONE:      return 32'h00000000;
    endcase
  endfunction : tmi_read

  assign awready = ce & ~s.aw_held & ~s.bvalid;
  assign wready  = ce & ~s.w_held & ~s.bvalid;
  assign arready = ce & ~s.rvalid;
  assign aw_hs   = awvalid & awready;
  assign w_hs    = wvalid & wready;
  assign ar_hs   = arvalid & arready;
  assign do_write = s.aw_held & s.w_held & ~s.bvalid;
  assign wsel    = tmi_decode(s.aw_addr);
  assign rsel    = tmi_decode({araddr[7:2], 2'h0});
  assign nib_sel  = tmi_nibble(wsel);
  assign flag_rep = {3{s.wdata[`TMI_BIT_HI_A_FLAG], s.wdata[`TMI_BIT_HI_P_FLAG],
                       s.wdata[`TMI_BIT_LO_A_FLAG], s.wdata[`TMI_BIT_LO_P_FLAG]}};
  assign en_rep   = {3{s.wdata[`TMI_BIT_HI_A_EN], s.wdata[`TMI_BIT_HI_P_EN],
                       s.wdata[`TMI_BIT_LO_A_EN], s.wdata[`TMI_BIT_LO_P_EN]}};

  // Write effects on the flag bank, as masks over the ten sources
  always_comb begin
    wr_fmask = 10'h000;
    wr_fval  = 10'h000;
    wr_clr   = 10'h000;
    if (do_write && s.wstrb[0]) begin
      wr_fmask = nib_sel[9:0];
      wr_fval  = flag_rep[9:0];
      if (wsel == TMI_SEL_STATUS) begin
        wr_clr[7:0] = s.wdata[7:0];
      end
    end
    if (do_write && s.wstrb[1] && wsel == TMI_SEL_STATUS) begin
      wr_clr[9:8] = s.wdata[9:8];
    end
  end

  tmi_flag_bank u_flags (
    .cur     (s.flag),
    .set     (10'(match_evt)),
    .wr_mask (wr_fmask),
    .wr_val  (wr_fval),
    .clr     (wr_clr),
    .impl    (IMPL),
    .nxt     (next_flag)
  );

  always_comb begin
    next_s      = s;
    next_s.flag = next_flag;
    if (aw_hs) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = {awaddr[7:2], 2'h0};
    end
    if (w_hs) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = wdata;
      next_s.wstrb  = wstrb;
    end
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = (wsel == TMI_SEL_NONE) ? `TMI_RESP_SLVERR : `TMI_RESP_OKAY;
      if (s.wstrb[0]) begin
        next_s.en = (s.en & ~nib_sel[9:0]) | (en_rep[9:0] & nib_sel[9:0]);
        if (wsel == TMI_SEL_MASK) begin
          next_s.en[7:0] = s.wdata[7:0];
        end
        if (wsel == TMI_SEL_CONTROL) begin
          next_s.gie = s.wdata[`TMI_BIT_GIE];
        end
      end
      if (s.wstrb[1] && wsel == TMI_SEL_MASK) begin
        next_s.en[9:8] = s.wdata[9:8];
      end
      next_s.en = next_s.en & IMPL;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (ar_hs) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = tmi_read(rsel, s);
      next_s.rresp  = (rsel == TMI_SEL_NONE) ? `TMI_RESP_SLVERR : `TMI_RESP_OKAY;
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0;
      s.flag <= `TMI_RST_FLAG;
      s.en   <= `TMI_RST_EN;
      s.gie  <= `TMI_RST_GIE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  tmi_irq_merge u_merge (
    .flag (s.flag),
    .en   (s.en),
    .gie  (s.gie),
    .req  (irq_req),
    .irq  (irq)
  );

  assign bvalid = s.bvalid;
  assign bresp  = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata  = s.rdata;
  assign rresp  = s.rresp;

endmodule : tmi_top

/* core/tmi_consts.svh */
// What this block does
// - Match event sets its request flag.
// - Enable bit zero blocks, one permits.
// - Compact register: flags 7..4, enables 3..0.
// - Periodic0 flags bits 5,4; enables 1,0.
// - Largest variant adds standard timer bits 7,6,3,2.
// - Periodic1 flags bits 5,4; enables 1,0.
// - Unimplemented bits always read zero.
// - Flag sets regardless; request needs enable.
// - Global enable low suppresses every interrupt.
`ifndef TMI_CONSTS_SVH
`define TMI_CONSTS_SVH

`define TMI_OFS_COMPACT     8'h00
`define TMI_OFS_PERIODIC0   8'h04
`define TMI_OFS_PERIODIC1   8'h08
`define TMI_OFS_CONTROL     8'h0C
`define TMI_OFS_STATUS      8'h10
`define TMI_OFS_MASK        8'h14

`define TMI_NSRC            10
`define TMI_NREG            3
`define TMI_BIT_HI_A_FLAG   7
`define TMI_BIT_HI_P_FLAG   6
`define TMI_BIT_LO_A_FLAG   5
`define TMI_BIT_LO_P_FLAG   4
`define TMI_BIT_HI_A_EN     3
`define TMI_BIT_HI_P_EN     2
`define TMI_BIT_LO_A_EN     1
`define TMI_BIT_LO_P_EN     0
`define TMI_BIT_GIE         0

`define TMI_RST_FLAG        10'h000
`define TMI_RST_EN          10'h000
`define TMI_RST_GIE         1'b0

`define TMI_RESP_OKAY       2'h0
`define TMI_RESP_SLVERR     2'h2

`endif

/* core/tmi_pkg.sv */
package tmi_pkg;

  // Bit 0 is compact timer 0 P match; each timer owns a P/A pair
  typedef struct packed {
    logic pt1_a;
    logic pt1_p;
    logic st0_a;
    logic st0_p;
    logic pt0_a;
    logic pt0_p;
    logic ct1_a;
    logic ct1_p;
    logic ct0_a;
    logic ct0_p;
  } tmi_src_s;

  typedef enum logic [6:0] {
    TMI_SEL_NONE      = 7'h01,
    TMI_SEL_COMPACT   = 7'h02,
    TMI_SEL_PERIODIC0 = 7'h04,
    TMI_SEL_PERIODIC1 = 7'h08,
    TMI_SEL_CONTROL   = 7'h10,
    TMI_SEL_STATUS    = 7'h20,
    TMI_SEL_MASK      = 7'h40
  } tmi_sel_e;

  typedef struct packed {
    logic [9:0]  flag;
    logic [9:0]  en;
    logic        gie;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tmi_state_s;

endpackage : tmi_pkg

/* core/tmi_flag_bank.sv */
`timescale 1ns/1ps
`include "tmi_consts.svh"
module tmi_flag_bank
  import tmi_pkg::*;
(
  input  wire logic [9:0] cur,     // Present flags
  input  wire logic [9:0] set,     // Match events
  input  wire logic [9:0] wr_mask, // Bits written directly
  input  wire logic [9:0] wr_val,  // Values written
  input  wire logic [9:0] clr,     // Write-one-to-clear bits
  input  wire logic [9:0] impl,    // Implemented bits
  output logic      [9:0] nxt      // Next flags
);
  logic [9:0] base;

  genvar g;
  generate
    for (g = 0; g < `TMI_NSRC; g++) begin : g_bit
      assign base[g] = (wr_mask[g] ? wr_val[g] : cur[g]) & ~clr[g];
      assign nxt[g]  = impl[g] & (base[g] | set[g]);
    end
  endgenerate
endmodule : tmi_flag_bank

/* core/tmi_irq_merge.sv */
`timescale 1ns/1ps
module tmi_irq_merge
  import tmi_pkg::*;
(
  input  wire logic [9:0] flag,    // Pending flags
  input  wire logic [9:0] en,      // Enables
  input  wire logic       gie,     // Global enable
  output tmi_src_s        req,     // Per-source requests
  output logic            irq      // Merged level
);
  assign req = tmi_src_s'(flag & en & {10{gie}});
  assign irq = |req;
endmodule : tmi_irq_merge

/* tb/tmi_timer_model.sv */
`timescale 1ns/1ps
module tmi_timer_model
  import tmi_pkg::*;
(
  input  wire logic       aclk,      // Clock
  input  wire logic [9:0] fire,      // Match request from the bench
  output tmi_src_s        match_evt  // Match pulses to the bank
);
  // One comparator strobe per requested cycle, idle low otherwise
  always_ff @(posedge aclk) begin
    match_evt <= tmi_src_s'(fire);
  end
endmodule : tmi_timer_model

/* tb/tmi_top_checker.sv */
`timescale 1ns/1ps
module tmi_top_checker
  import tmi_pkg::*;
(
  input  wire logic        aclk,      // Clock
  input  wire logic        aresetn,   // Reset, low
  input  tmi_src_s         match_evt, // Timer events
  input  tmi_src_s         irq_req,   // Per-source requests
  input  logic             irq,       // Merged level
  input  logic             awready,   // Write address ready
  input  logic             wready,    // Write data ready
  input  logic [1:0]       bresp,     // Write response
  input  logic             bvalid,    // Write response valid
  input  wire logic        bready,    // Write response ready
  input  wire logic        arvalid,   // Read address valid
  input  logic             arready,   // Read address ready
  input  logic [31:0]      rdata,     // Read data
  input  logic             rvalid,    // Read data valid
  input  wire logic        rready     // Read data ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_irq_merge; irq == (irq_req != 10'h0); endproperty
  a_irq_merge: assert property (p_irq_merge)
    else $error("irq differs from the OR of requests");
  property p_reset_clear; $rose(aresetn) |-> !irq && !bvalid && !rvalid; endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not clear after reset");
  property p_set_cause;
    (irq_req & ~$past(irq_req) & ~$past(match_evt)) != 10'h0 |-> $rose(bvalid);
  endproperty
  a_set_cause: assert property (p_set_cause)
    else $error("request rose without event or write");
  property p_sticky; (~irq_req & $past(irq_req)) != 10'h0 |-> $rose(bvalid); endproperty
  a_sticky: assert property (p_sticky)
    else $error("request dropped without a write");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_r_answer; arvalid && arready |=> rvalid; endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
  property p_aw_block; bvalid |-> !awready && !wready; endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write taken while response pending");
endmodule : tmi_top_checker

bind tmi_top tmi_top_checker u_chk (.aclk, .aresetn, .match_evt, .irq_req, .irq, .awready,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready);

/* tb/tmi_top_bench.sv */
`timescale 1ns/1ps
`include "tmi_consts.svh"
module tmi_top_bench
  import tmi_pkg::*;
;
  logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [9:0]  fire;
  tmi_src_s    evt, irq_req;
  tmi_src_s    irq_req_small;
  logic [31:0] rdata_small, q_small;
  int          n_mismatch, tests_run, i;
  // Register offset and expected 8-bit view per source
  logic [15:0] rows [10] = '{16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0410,
                             16'h0420, 16'h0440, 16'h0480, 16'h0810, 16'h0820};
  tmi_top DUT (.aclk, .aresetn, .ce, .match_evt(evt), .irq_req, .irq, .awaddr,
    .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  tmi_timer_model u_tmr (.aclk, .fire, .match_evt(evt));
  // Smaller variant on the same bus, only its read data and requests watched
  tmi_top #(.HAS_CT1(1'b0), .HAS_ST0(1'b0), .HAS_PT1(1'b1)) DUT_small (.aclk, .aresetn, .ce,
    .match_evt(evt), .irq_req(irq_req_small), .irq(), .awaddr, .awprot(3'h0), .awvalid,
    .awready(), .wdata, .wstrb, .wvalid, .wready(), .bresp(), .bvalid(), .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready(), .rdata(rdata_small), .rresp(), .rvalid(), .rready);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Bus cycle; ready signals sampled mid-cycle, valids released after the taking edge
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    bit ha, hw, hb;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      ha = (awvalid & awready) | (arvalid & arready);
      hw = wvalid & wready;
      hb = w ? bvalid : rvalid;
      q = rdata;
      q_small = rdata_small;
      r = w ? bresp : rresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (ha) arvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) return;
    end
    n_mismatch++;
    conclude();
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, a, d, q, r);
    chk("bresp", r, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, a, 32'h0, q, r);
    chk("rdata", q, e);
    chk("rresp", r, er);
  endtask : rd

  task automatic pulse(input logic [9:0] v);
    fire <= v;
    @(posedge aclk);
    fire <= 10'h000;
    repeat (2) @(posedge aclk);
  endtask : pulse

  task automatic lvl(input logic [9:0] e);
    @(negedge aclk);
    chk("irq_req", 32'(irq_req), 32'(e));
    chk("irq", 32'(irq), 32'(e != 10'h000));
    @(posedge aclk);
  endtask : lvl

  initial begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {ce, bready, rready, wstrb, fire} = {3'h7, 4'hF, 10'h000};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, `TMI_RESP_OKAY);
    $display("test reset done");
    for (i = 0; i < 10; i++) begin
      pulse(10'h001 << i);
      rd(rows[i][15:8], 32'(rows[i][7:0]), `TMI_RESP_OKAY);
      rd(`TMI_OFS_STATUS, 32'h1 << i, `TMI_RESP_OKAY);
      chk("status_small", q_small, 32'(10'h333 & (10'h001 << i)));
      wr(rows[i][15:8], 32'h0, `TMI_RESP_OKAY);
      rd(rows[i][15:8], 32'h0, `TMI_RESP_OKAY);
    end
    $display("test events done");
    for (i = 0; i < 3; i++) wr(8'(4 * i), 32'hFF, `TMI_RESP_OKAY);
    rd(`TMI_OFS_COMPACT, 32'hFF, `TMI_RESP_OKAY);
    chk("compact_small", q_small, 32'h33);
    rd(`TMI_OFS_PERIODIC0, 32'hFF, `TMI_RESP_OKAY);
    chk("periodic0_small", q_small, 32'h33);
    rd(`TMI_OFS_PERIODIC1, 32'h33, `TMI_RESP_OKAY);
    chk("periodic1_small", q_small, 32'h33);
    lvl(10'h000);
    wr(`TMI_OFS_CONTROL, 32'h1, `TMI_RESP_OKAY);
    lvl(10'h3FF);
    @(negedge aclk);
    chk("irq_req_small", 32'(irq_req_small), 32'h333);
    @(posedge aclk);
    wr(`TMI_OFS_MASK, 32'h008, `TMI_RESP_OKAY);
    lvl(10'h008);
    wr(`TMI_OFS_STATUS, 32'h3FF, `TMI_RESP_OKAY);
    lvl(10'h000);
    pulse(10'h004);
    lvl(10'h000);
    pulse(10'h008);
    lvl(10'h008);
    wr(`TMI_OFS_CONTROL, 32'h0, `TMI_RESP_OKAY);
    lvl(10'h000);
    $display("test mask done");
    wr(8'h20, 32'h1, `TMI_RESP_SLVERR);
    rd(8'h20, 32'h0, `TMI_RESP_SLVERR);
    $display("test unmapped done");
    ce <= 1'b0;
    pulse(10'h001);
    ce <= 1'b1;
    rd(`TMI_OFS_STATUS, 32'h00C, `TMI_RESP_OKAY);
    $display("test enable done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`TMI_OFS_STATUS, 32'h0, `TMI_RESP_OKAY);
    rd(`TMI_OFS_MASK, 32'h0, `TMI_RESP_OKAY);
    $display("test second reset done");
    conclude();
  end
endmodule : tmi_top_bench
